// File: pkg/psl_cfg.svh
// Timing counts, setting codes and reset defaults of the serial link master.
`ifndef PSL_CFG_SVH
`define PSL_CFG_SVH
`define PSL_CLK_HZ        10000000
`define PSL_CLK_NS        100
`define PSL_MS_NS         1000000
`define PSL_MS_CYC        (`PSL_MS_NS / `PSL_CLK_NS)
`define PSL_DIV_9600      (`PSL_CLK_HZ / 9600)
`define PSL_DIV_19200     (`PSL_CLK_HZ / 19200)
`define PSL_DIV_38400     (`PSL_CLK_HZ / 38400)
`define PSL_DIV_57600     (`PSL_CLK_HZ / 57600)
`define PSL_DIV_115200    (`PSL_CLK_HZ / 115200)
`define PSL_RATE_9600     3'h3
`define PSL_RATE_19200    3'h4
`define PSL_RATE_38400    3'h5
`define PSL_RATE_57600    3'h6
`define PSL_RATE_115200   3'h7
`define PSL_DEF_RATE      3'h7
`define PSL_DEF_LEN       1'h1
`define PSL_DEF_PARITY    2'h1
`define PSL_PAR_NONE      2'h0
`define PSL_PAR_EVEN      2'h1
`define PSL_PAR_ODD       2'h2
`define PSL_DEF_STOP      1'h0
`define PSL_DEF_SWAIT     7'h05
`define PSL_MAX_SWAIT     7'h63
`define PSL_DEF_RWAIT     14'h07D0
`define PSL_MIN_RWAIT     14'h000A
`define PSL_MAX_RWAIT     14'h2710
`define PSL_DEF_ERRSTOP   1'h1
`define PSL_LIM_WIDE      15'h7FFF
`define PSL_LIM_DREG      15'h2FFF
`define PSL_LIM_LREG      15'h1FFF
`define PSL_AREA_DREG     4'h0
`define PSL_AREA_LREG     4'h1
`define PSL_AREA_FREG     4'h2
`define PSL_STOP_WORD     16'hEEEE
`endif

// File: pkg/psl_pkg.sv
// Types shared by the serial link master.
package psl_pkg;
   typedef enum logic [2:0] {
      PSL_PROTO_TERM = 3'h2,
      PSL_PROTO_CPU  = 3'h4,
      PSL_PROTO_BIN5 = 3'h5
   } psl_proto_t;
   typedef enum logic [3:0] {
      PSL_ST_IDLE  = 4'h1,
      PSL_ST_WAIT  = 4'h2,
      PSL_ST_SHIFT = 4'h4,
      PSL_ST_RESP  = 4'h8
   } psl_st_t;
endpackage

// File: hdl/psl_link_master.sv
// Serial link master: framing, send wait, response timeout and error policy.
`timescale 1ns/1ps
`include "psl_cfg.svh"
module psl_link_master #(
   parameter int unsigned MS_CYC = `PSL_MS_CYC
) (
   // Clock, reset and enable.
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   // Link settings, sampled once after reset.
   input  wire psl_pkg::psl_proto_t  cfg_proto,
   input  wire logic [3:0]           cfg_area,
   input  wire logic [14:0]          cfg_start,
   input  wire logic [2:0]           cfg_rate,
   input  wire logic                 cfg_len,
   input  wire logic [1:0]           cfg_parity,
   input  wire logic                 cfg_stop,
   input  wire logic [6:0]           cfg_swait,
   input  wire logic [13:0]          cfg_rwait,
   input  wire logic                 cfg_err_stop,
   // Command bytes to send.
   input  wire logic                 tx_valid,
   input  wire logic [7:0]           tx_data,
   input  wire logic                 tx_last,
   output logic                      tx_ready,
   // Received bytes and response completion.
   output logic                      rx_valid,
   output logic [7:0]                rx_data,
   output logic                      rx_err,
   input  wire logic                 resp_done,
   // Serial pins.
   output logic                      txd,
   input  wire logic                 rxd,
   // Status.
   output logic                      link_err,
   output logic                      stopped,
   output logic                      op_resp_valid,
   output logic [15:0]               op_resp_word,
   output logic                      addr_ok,
   input  wire logic [31:0]          unit_fail,
   output logic [31:0]               err_status
);
   import psl_pkg::*;

   // Snapshot of the settings; held until the next reset.
   logic                         load_q, len_q, stop_q, errstop_q, aok_q, aok_d;
   logic [2:0]                   rate_q, proto_q;
   logic [1:0]                   par_q;
   logic [6:0]                   swait_q;
   logic [13:0]                  rwait_q, rwait_c;
   logic [14:0]                  lim_c;
   logic                         term_c;

   // Unknown protocol codes fall back to the terminal link default.
   assign term_c = !(cfg_proto == PSL_PROTO_CPU || cfg_proto == PSL_PROTO_BIN5);
   always_comb begin
      unique case (cfg_area)
         `PSL_AREA_DREG: lim_c = `PSL_LIM_DREG;
         `PSL_AREA_LREG: lim_c = `PSL_LIM_LREG;
         default:        lim_c = `PSL_LIM_WIDE;
      endcase
      if (term_c) begin
         lim_c = `PSL_LIM_WIDE;
      end
      aok_d = (cfg_start <= lim_c);
      rwait_c = cfg_rwait;
      if (cfg_rwait < `PSL_MIN_RWAIT) begin
         rwait_c = `PSL_MIN_RWAIT;
      end else if (cfg_rwait > `PSL_MAX_RWAIT) begin
         rwait_c = `PSL_MAX_RWAIT;
      end
   end

   // Settings change only here, on the first enabled edge after reset.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         load_q <= 1'b0;
         proto_q <= PSL_PROTO_TERM;
         rate_q <= `PSL_DEF_RATE;
         len_q <= `PSL_DEF_LEN;
         par_q <= `PSL_DEF_PARITY;
         stop_q <= `PSL_DEF_STOP;
         swait_q <= `PSL_DEF_SWAIT;
         rwait_q <= `PSL_DEF_RWAIT;
         errstop_q <= `PSL_DEF_ERRSTOP;
         aok_q <= 1'b0;
      end else if (ce && !load_q) begin
         load_q <= 1'b1;
         proto_q <= term_c ? PSL_PROTO_TERM : cfg_proto;
         errstop_q <= cfg_err_stop;
         rwait_q <= rwait_c;
         aok_q <= aok_d;
         if (!term_c) begin
            rate_q <= (cfg_rate < `PSL_RATE_9600) ? `PSL_DEF_RATE : cfg_rate;
            len_q <= cfg_len;
            par_q <= (cfg_parity > `PSL_PAR_ODD) ? `PSL_DEF_PARITY : cfg_parity;
            stop_q <= cfg_stop;
            swait_q <= (cfg_swait > `PSL_MAX_SWAIT) ? `PSL_MAX_SWAIT : cfg_swait;
         end
      end
   end

   // Bit period and frame shape derived from the snapshot.
   logic [10:0] div_c;
   logic [3:0]  dl_c, nbits_c;
   always_comb begin
      unique case (rate_q)
         `PSL_RATE_9600:  div_c = 11'(`PSL_DIV_9600);
         `PSL_RATE_19200: div_c = 11'(`PSL_DIV_19200);
         `PSL_RATE_38400: div_c = 11'(`PSL_DIV_38400);
         `PSL_RATE_57600: div_c = 11'(`PSL_DIV_57600);
         default:         div_c = 11'(`PSL_DIV_115200);
      endcase
      dl_c = len_q ? 4'h8 : 4'h7;
      nbits_c = 4'h2 + dl_c + {3'h0, par_q != `PSL_PAR_NONE} + {3'h0, stop_q};
   end

   // Transmit sequencer with millisecond timer.
   psl_st_t     st_q, st_d;
   logic [10:0] bcnt_q, bcnt_d;
   logic [3:0]  bidx_q, bidx_d;
   logic [7:0]  byte_q, byte_d;
   logic        last_q, last_d, first_q, first_d, txd_q, txd_d, rdy_q, rdy_d;
   logic [13:0] pre_q, pre_d, ms_q, ms_d;
   logic        stp_q, stp_d, lerr_q, lerr_d, opv_q, opv_d, fail_c, tick_c, bit_c;
   logic [15:0] opw_q, opw_d;
   logic        rxv_q, rxe_q;

   always_comb begin
      st_d = st_q;
      bcnt_d = bcnt_q;
      bidx_d = bidx_q;
      byte_d = byte_q;
      last_d = last_q;
      first_d = first_q;
      stp_d = stp_q;
      lerr_d = lerr_q;
      opv_d = 1'b0;
      opw_d = opw_q;
      pre_d = pre_q;
      ms_d = ms_q;
      fail_c = 1'b0;
      tick_c = (pre_q == 14'(MS_CYC - 1));
      // Frame bit at the current index: start, data LSB first, parity, stops.
      if (bidx_q == 4'h0) begin
         bit_c = 1'b0;
      end else if (bidx_q <= dl_c) begin
         bit_c = byte_q[3'(bidx_q - 4'h1)];
      end else if (bidx_q == dl_c + 4'h1 && par_q != `PSL_PAR_NONE) begin
         bit_c = (^(len_q ? byte_q : {1'b0, byte_q[6:0]})) ^ (par_q == `PSL_PAR_ODD);
      end else begin
         bit_c = 1'b1;
      end
      unique case (st_q)
         PSL_ST_IDLE: begin
            ms_d = 14'h0;
            pre_d = 14'h0;
            if (rdy_q && tx_valid) begin
               byte_d = tx_data;
               last_d = tx_last;
               bidx_d = 4'h0;
               bcnt_d = div_c;
               st_d = (first_q && swait_q != 7'h0) ? PSL_ST_WAIT : PSL_ST_SHIFT;
            end
         end
         PSL_ST_WAIT: begin
            pre_d = tick_c ? 14'h0 : pre_q + 14'h1;
            if (tick_c) begin
               ms_d = ms_q + 14'h1;
               if (ms_q + 14'h1 >= {7'h0, swait_q}) begin
                  st_d = PSL_ST_SHIFT;
               end
            end
         end
         PSL_ST_SHIFT: begin
            bcnt_d = bcnt_q - 11'h1;
            if (bcnt_q == 11'h0) begin
               bcnt_d = div_c;
               bidx_d = bidx_q + 4'h1;
               if (bidx_q == nbits_c - 4'h1) begin
                  first_d = last_q;
                  ms_d = 14'h0;
                  pre_d = 14'h0;
                  st_d = last_q ? PSL_ST_RESP : PSL_ST_IDLE;
               end
            end
         end
         PSL_ST_RESP: begin
            pre_d = tick_c ? 14'h0 : pre_q + 14'h1;
            if (tick_c) begin
               ms_d = ms_q + 14'h1;
            end
            if (resp_done) begin
               lerr_d = 1'b0;
               st_d = PSL_ST_IDLE;
            end else if (ms_q >= rwait_q || (rxv_q && rxe_q)) begin
               fail_c = 1'b1;
            end
         end
         default: st_d = PSL_ST_IDLE;
      endcase
      // A failed exchange either stops the link for good or lets polling go on.
      if (fail_c) begin
         lerr_d = 1'b1;
         st_d = PSL_ST_IDLE;
         if (errstop_q) begin
            stp_d = 1'b1;
            opv_d = 1'b1;
            opw_d = `PSL_STOP_WORD;
         end
      end
      rdy_d = (st_d == PSL_ST_IDLE) && !stp_d && load_q && !(rdy_q && tx_valid);
      txd_d = (st_q == PSL_ST_SHIFT) ? bit_c : 1'b1;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= PSL_ST_IDLE;
         bcnt_q <= 11'h0;
         bidx_q <= 4'h0;
         byte_q <= 8'h0;
         last_q <= 1'b0;
         first_q <= 1'b1;
         txd_q <= 1'b1;
         rdy_q <= 1'b0;
         pre_q <= 14'h0;
         ms_q <= 14'h0;
         stp_q <= 1'b0;
         lerr_q <= 1'b0;
         opv_q <= 1'b0;
         opw_q <= 16'h0;
      end else if (ce) begin
         st_q <= st_d;
         bcnt_q <= bcnt_d;
         bidx_q <= bidx_d;
         byte_q <= byte_d;
         last_q <= last_d;
         first_q <= first_d;
         txd_q <= txd_d;
         rdy_q <= rdy_d;
         pre_q <= pre_d;
         ms_q <= ms_d;
         stp_q <= stp_d;
         lerr_q <= lerr_d;
         opv_q <= opv_d;
         opw_q <= opw_d;
      end
   end

   // Receiver samples mid-bit; a stop bit read low counts as a character error.
   logic        ron_q, ron_d, rxv_d, rxe_d;
   logic [10:0] rcnt_q, rcnt_d;
   logic [3:0]  ridx_q, ridx_d;
   logic [7:0]  rsh_q, rsh_d;
   logic        rpar_q, rpar_d;
   logic [31:0] est_q;
   always_comb begin
      ron_d = ron_q;
      rcnt_d = rcnt_q;
      ridx_d = ridx_q;
      rsh_d = rsh_q;
      rpar_d = rpar_q;
      rxv_d = 1'b0;
      rxe_d = rxe_q;
      if (!ron_q) begin
         if (!rxd && load_q) begin
            ron_d = 1'b1;
            rcnt_d = div_c >> 1;
            ridx_d = 4'h0;
            rsh_d = 8'h0;
         end
      end else if (rcnt_q != 11'h0) begin
         rcnt_d = rcnt_q - 11'h1;
      end else begin
         rcnt_d = div_c;
         ridx_d = ridx_q + 4'h1;
         if (ridx_q == 4'h0 && rxd) begin
            ron_d = 1'b0;  // Glitch, not a start bit.
         end else if (ridx_q != 4'h0 && ridx_q <= dl_c) begin
            rsh_d[3'(ridx_q - 4'h1)] = rxd;
         end else if (ridx_q == dl_c + 4'h1 && par_q != `PSL_PAR_NONE) begin
            rpar_d = rxd;
         end else if (ridx_q != 4'h0) begin
            ron_d = 1'b0;
            rxv_d = 1'b1;
            rxe_d = !rxd || (par_q != `PSL_PAR_NONE &&
                     ((^rsh_q) ^ rpar_q ^ (par_q == `PSL_PAR_ODD)));
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ron_q <= 1'b0;
         rcnt_q <= 11'h0;
         ridx_q <= 4'h0;
         rsh_q <= 8'h0;
         rpar_q <= 1'b0;
         rxv_q <= 1'b0;
         rxe_q <= 1'b0;
         est_q <= 32'h0;
      end else if (ce) begin
         ron_q <= ron_d;
         rcnt_q <= rcnt_d;
         ridx_q <= ridx_d;
         rsh_q <= rsh_d;
         rpar_q <= rpar_d;
         rxv_q <= rxv_d;
         rxe_q <= rxe_d;
         est_q <= unit_fail;
      end
   end

   // Outputs are all registered.
   assign tx_ready = rdy_q;
   assign rx_valid = rxv_q;
   assign rx_data = rsh_q;
   assign rx_err = rxe_q;
   assign txd = txd_q;
   assign link_err = lerr_q;
   assign stopped = stp_q;
   assign op_resp_valid = opv_q;
   assign op_resp_word = opw_q;
   assign addr_ok = aok_q;
   assign err_status = est_q;

   // Checks on the sequencer, the snapshot and the error status copy.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // A failed exchange: the receive wait ran out or the reply held a bad character.
   sequence s_fail;
      ce && st_q == PSL_ST_RESP && !resp_done && (ms_q >= rwait_q || (rxv_q && rxe_q));
   endsequence
   a_start_low:   assert property (ce && st_q == PSL_ST_SHIFT && bidx_q == 4'h0 |=> !txd_q)
      else $error("start bit not low");
   a_stop_high:   assert property (ce && st_q == PSL_ST_SHIFT && bidx_q > dl_c +
      {3'h0, par_q != `PSL_PAR_NONE} |=> txd_q) else $error("stop bit not high");
   a_baud_bound:  assert property (st_q == PSL_ST_SHIFT |-> bcnt_q <= div_c)
      else $error("bit counter beyond period");
   a_frame_end:   assert property (ce && st_q == PSL_ST_SHIFT && bcnt_q == 11'h0 &&
      bidx_q == nbits_c - 4'h1 |=> st_q != PSL_ST_SHIFT) else $error("frame length wrong");
   a_send_wait:   assert property (ce && st_q == PSL_ST_IDLE && rdy_q && tx_valid &&
      first_q && swait_q != 7'h0 |=> st_q == PSL_ST_WAIT) else $error("send wait skipped");
   a_term_def:    assert property (load_q && proto_q == PSL_PROTO_TERM |->
      rate_q == `PSL_DEF_RATE && swait_q == `PSL_DEF_SWAIT && len_q == `PSL_DEF_LEN)
      else $error("terminal link settings not default");
   a_timeout:     assert property (s_fail |=> link_err)
      else $error("timeout not flagged");
   a_cfg_frozen:  assert property (load_q |=> $stable(rate_q) && $stable(proto_q) &&
      $stable(errstop_q)) else $error("settings changed without reset");
   a_stop_word:   assert property (s_fail ##0 errstop_q |=> op_resp_valid && stopped &&
      op_resp_word == `PSL_STOP_WORD ##1 !tx_ready [*2]) else $error("stop policy broken");
   a_continue:    assert property (s_fail ##0 !errstop_q |=> !stopped)
      else $error("continue policy stopped link");
   a_err_status:  assert property (ce ##1 1'b1 |-> err_status == $past(unit_fail))
      else $error("error status not following sub-units");
endmodule

// File: bench/psl_plc_model.sv
// Behavioural controller-side serial unit: decodes frames and answers them.
`timescale 1ns/1ps
module psl_plc_model (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        nrst,
   // Serial lines.
   input  wire logic        txd,
   output logic             rxd,
   // Framing in force and reply control.
   input  wire logic [31:0] bitc,
   input  wire logic        len,
   input  wire logic [1:0]  parity,
   input  wire logic        stop,
   input  wire logic [31:0] want,
   input  wire logic        bad_par,
   // Decoded characters and start times of the last two frames.
   output logic [15:0]      got_pair,
   output logic             got_bad,
   output int               got_cnt,
   output time              t_prev,
   output time              t_last
);
   logic [7:0] d;
   logic       ok;
   int         i;
   int         gen = 1;
   int         gen_seen = 0;

   // One bit on the reply line, changed just after an edge.
   task automatic bit_out(input logic b);
      #1 rxd = b;
      repeat (bitc) @(posedge clk);
   endtask

   // A reply frame; a wrong parity bit is sent only when asked for.
   task automatic put(input logic [7:0] v);
      int k;
      bit_out(1'b0);
      for (k = 0; k < (len ? 8 : 7); k++) bit_out(v[k]);
      if (parity != 2'h0) bit_out(^v ^ (parity == 2'h2) ^ bad_par);
      repeat (stop ? 2 : 1) bit_out(1'b1);
   endtask

   // Every device reset restarts the tallies; they are cleared at the next frame so that
   // only the decoding process writes them.
   always @(negedge nrst) begin
      gen++;
   end

   // Sample each frame at mid-bit; the line idles high between frames.
   initial rxd = 1'b1;
   always begin
      @(negedge txd);
      if (nrst === 1'b1) begin
         if (gen != gen_seen) begin
            got_cnt = 0;
            got_bad = 1'b0;
            gen_seen = gen;
         end
         t_prev = t_last;
         t_last = $time;
         d = 8'h00;
         repeat (bitc / 2) @(posedge clk);
         ok = (txd === 1'b0);
         for (i = 0; i < (len ? 8 : 7); i++) begin
            repeat (bitc) @(posedge clk);
            d[i] = txd;
         end
         if (parity != 2'h0) begin
            repeat (bitc) @(posedge clk);
            ok = ok & (txd === (^d ^ (parity == 2'h2)));
         end
         repeat (stop ? 2 : 1) begin
            repeat (bitc) @(posedge clk);
            ok = ok & (txd === 1'b1);
         end
         got_pair = {got_pair[7:0], d};
         got_bad = got_bad | ~ok;
         got_cnt++;
         // Answer only once the device has finished sending.
         if (got_cnt == want) begin
            repeat (bitc) @(posedge clk);
            put(~d & (len ? 8'hFF : 8'h7F));
         end
      end
   end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the serial link master.
`timescale 1ns/1ps
`include "psl_cfg.svh"
module testbench;
   import psl_pkg::*;
   typedef struct packed {
      logic [2:0]  proto;
      logic [3:0]  area;
      logic [14:0] start;
      logic [2:0]  rate;
      logic        len;
      logic [1:0]  par;
      logic        stop;
      logic [6:0]  swait;
      logic [7:0]  b0;
      logic [7:0]  b1;
      logic        aok;
   } psl_row_t;
   localparam int MSC = 20;
   logic        clk = 1'b0;
   logic        nrst, ce, cfg_len, cfg_stop, cfg_err_stop, tx_valid, tx_last, tx_ready;
   logic        rx_valid, rx_err, resp_done, txd, rxd, link_err, stopped, op_resp_valid;
   logic        addr_ok, e_len, e_stop, bad_par, got_bad;
   psl_proto_t  cfg_proto;
   logic [3:0]  cfg_area;
   logic [14:0] cfg_start;
   logic [2:0]  cfg_rate;
   logic [1:0]  cfg_parity, e_par;
   logic [6:0]  cfg_swait;
   logic [13:0] cfg_rwait;
   logic [7:0]  tx_data, rx_data;
   logic [15:0] op_resp_word, got_pair;
   logic [31:0] unit_fail, err_status;
   int          bitc, want, got_cnt, bad_count, checked;
   time         t_prev, t_last, t_take;
   psl_row_t    rows [8];

   psl_link_master #(.MS_CYC(MSC)) i_psl_link_master (.clk, .nrst, .ce, .cfg_proto,
      .cfg_area, .cfg_start, .cfg_rate, .cfg_len, .cfg_parity, .cfg_stop, .cfg_swait,
      .cfg_rwait, .cfg_err_stop, .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_valid,
      .rx_data, .rx_err, .resp_done, .txd, .rxd, .link_err, .stopped, .op_resp_valid,
      .op_resp_word, .addr_ok, .unit_fail, .err_status);
   psl_plc_model i_psl_plc_model (.clk, .nrst, .txd, .rxd, .bitc, .len(e_len),
      .parity(e_par), .stop(e_stop), .want, .bad_par, .got_pair, .got_bad, .got_cnt,
      .t_prev, .t_last);

   // Free-running clock of 100 ns.
   always #50 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   function automatic logic pick(input int w);
      return (w == 0) ? tx_ready : (w == 1) ? rx_valid : link_err;
   endfunction

   // Bounded wait; running out counts as a mismatch and ends the run.
   task automatic wait_for(input int w, input int lim);
      int n;
      n = 0;
      while (pick(w) !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > lim) begin
            bad_count++;
            test_done();
         end
      end
   endtask

   // Request held until the edge that sees tx_ready high.
   task automatic send(input logic [7:0] b, input logic last);
      wait_for(0, 30000);
      tx_valid = 1'b1;
      tx_data = b;
      tx_last = last;
      @(posedge clk);
      t_take = $time;
      #1 tx_valid = 1'b0;
   endtask

   task automatic pulse_done();
      resp_done = 1'b1;
      @(posedge clk);
      #1 resp_done = 1'b0;
   endtask

   task automatic do_reset();
      nrst = 1'b0;
      repeat (4) @(posedge clk);
      #1 nrst = 1'b1;
   endtask

   function automatic logic in_win(input longint v, input longint lo);
      return v >= lo && v <= lo + 24;
   endfunction

   initial begin
      psl_row_t r;
      int nb, sw;
      logic [7:0] m;
      time t0;
      logic hit;
      {ce, tx_valid, tx_last, resp_done, bad_par, cfg_err_stop} = 6'b100001;
      {tx_data, unit_fail, bad_count, checked, want} = '0;
      {cfg_area, cfg_start} = '0;
      cfg_rwait = `PSL_DEF_RWAIT;
      rows = '{'{3'h4, 4'h0, 15'h2FFF, 3'h7, 1'b1, 2'h1, 1'b0, 7'h05, 8'hA5, 8'h3C, 1'b1},
               '{3'h4, 4'h0, 15'h3000, 3'h3, 1'b0, 2'h2, 1'b1, 7'h00, 8'h55, 8'h7F, 1'b0},
               '{3'h5, 4'h1, 15'h1FFF, 3'h4, 1'b1, 2'h0, 1'b1, 7'h02, 8'h0F, 8'hF0, 1'b1},
               '{3'h4, 4'h1, 15'h2000, 3'h5, 1'b0, 2'h1, 1'b0, 7'h01, 8'h6B, 8'h12, 1'b0},
               '{3'h5, 4'h2, 15'h7FFF, 3'h6, 1'b1, 2'h2, 1'b0, 7'h03, 8'hC3, 8'h81, 1'b1},
               '{3'h2, 4'h1, 15'h7FFF, 3'h3, 1'b0, 2'h0, 1'b1, 7'h00, 8'h96, 8'hE1, 1'b1},
               '{3'h3, 4'h0, 15'h3000, 3'h4, 1'b0, 2'h2, 1'b1, 7'h09, 8'h5E, 8'h21, 1'b1},
               '{3'h4, 4'h2, 15'h0000, 3'h2, 1'b1, 2'h3, 1'b0, 7'h70, 8'hE7, 8'h18, 1'b1}};
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("rst_out", {txd, tx_ready, link_err, stopped, op_resp_valid, addr_ok}, 6'h20);
      // Each row: fresh reset, two-byte command, reply, completion.
      foreach (rows[k]) begin
         r = rows[k];
         // One region per row; addr_ok shows whether the start address fits its limit.
         {cfg_area, cfg_start, cfg_rate, cfg_len} = {r.area, r.start, r.rate, r.len};
         {cfg_parity, cfg_stop, cfg_swait} = {r.par, r.stop, r.swait};
         cfg_proto = psl_proto_t'(r.proto);
         if (r.proto == 3'h4 || r.proto == 3'h5) begin
            e_len = r.len;
            e_stop = r.stop;
            e_par = (r.par == 2'h3) ? `PSL_DEF_PARITY : r.par;
            sw = (r.swait > `PSL_MAX_SWAIT) ? 99 : int'(r.swait);
            nb = (r.rate < 3'h3) ? 7 : int'(r.rate);
         end else begin
            {e_len, e_stop, e_par} = {`PSL_DEF_LEN, `PSL_DEF_STOP, `PSL_DEF_PARITY};
            sw = 5;
            nb = 7;
         end
         bitc = `PSL_CLK_HZ / (nb == 3 ? 9600 : nb == 4 ? 19200 : nb == 5 ? 38400 :
                nb == 6 ? 57600 : 115200) + 1;
         nb = 1 + (e_len ? 8 : 7) + (e_par != 2'h0) + (e_stop ? 2 : 1);
         m = e_len ? 8'hFF : 8'h7F;
         want = 2;
         do_reset();
         wait_for(0, 100);
         chk("addr_ok", addr_ok, r.aok);
         // Settings changed after reset must have no effect until the next one.
         {cfg_rate, cfg_len, cfg_stop, cfg_swait} = {3'h3, ~r.len, ~r.stop, 7'h00};
         send(r.b0, 1'b0);
         t0 = t_take;
         send(r.b1, 1'b1);
         wait_for(1, 40000);
         chk("rx_char", {rx_err, rx_data}, {1'b0, ~r.b1 & m});
         chk("frames", {got_bad, got_pair}, {1'b0, r.b0 & m, r.b1 & m});
         chk("swait", in_win((t_prev - t0) / 100, sw * MSC), 1'b1);
         chk("gap", in_win((t_last - t_prev) / 100, nb * bitc), 1'b1);
         // Let the partner finish its stop bits, or it misses the next row's first frame.
         repeat (2 * bitc) @(posedge clk);
         #1 pulse_done();
         wait_for(0, 100);
         chk("link_ok", {link_err, stopped}, 2'b00);
      end
      // Sub-unit failures show in the status one cycle later.
      unit_fail = 32'h8000_0001;
      chk("err_early", err_status, 32'h0);
      @(posedge clk);
      #1 chk("err_stat", err_status, 32'h8000_0001);
      // With the clock enable low the status must keep its old copy.
      {ce, unit_fail} = {1'b0, 32'h0};
      @(posedge clk);
      #1 chk("ce_hold", err_status, 32'h8000_0001);
      ce = 1'b1;
      // No reply under the stop policy: timeout, then never ready again.
      {cfg_rate, cfg_len, cfg_stop, cfg_swait} = {3'h7, 1'b1, 1'b0, 7'h05};
      cfg_rwait = `PSL_MIN_RWAIT;
      want = 0;
      do_reset();
      send(8'h5A, 1'b1);
      wait_for(2, 5000);
      chk("timeout", in_win(($time - t_take) / 100, 100 + 11 * 87 + 10 * MSC), 1'b1);
      chk("stop_word", {op_resp_valid, stopped, op_resp_word}, {2'b11, `PSL_STOP_WORD});
      hit = 1'b0;
      tx_valid = 1'b1;
      repeat (300) begin
         @(posedge clk);
         #1 hit = hit | tx_ready | ~txd;
      end
      chk("no_more", hit, 1'b0);
      tx_valid = 1'b0;
      // Continue policy: a bad reply fails the link, polling then resumes.
      {cfg_rwait, cfg_err_stop, bad_par} = {`PSL_DEF_RWAIT, 1'b0, 1'b1};
      want = 1;
      do_reset();
      send(8'h33, 1'b1);
      wait_for(1, 5000);
      chk("par_err", rx_err, 1'b1);
      wait_for(2, 4);
      chk("cont", stopped, 1'b0);
      bad_par = 1'b0;
      want = 2;
      send(8'h44, 1'b1);
      wait_for(1, 5000);
      chk("resume", {rx_err, rx_data}, 9'h0BB);
      pulse_done();
      chk("recover", link_err, 1'b0);
      test_done();
   end
endmodule
